// ### hdl/pll_ctrl_pkg.sv
package pll_ctrl_pkg;

  // Bus and register map
  localparam int          AXI_AW          = 6;
  localparam logic [5:0]  OFS_CTRL        = 6'h00;
  localparam logic [5:0]  OFS_DIV         = 6'h04;
  localparam logic [5:0]  OFS_OUTDIV      = 6'h08;
  localparam logic [5:0]  OFS_PHASE       = 6'h0C;
  localparam logic [5:0]  OFS_STATUS      = 6'h10;
  localparam logic [5:0]  OFS_IRQ_STAT    = 6'h14;
  localparam logic [5:0]  OFS_IRQ_MASK    = 6'h18;
  localparam logic [5:0]  OFS_PHASE_CUR   = 6'h1C;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Control register fields
  localparam int          CTRL_RUN_BIT    = 0;
  localparam int          CTRL_SEL_LSB    = 4;
  localparam logic [31:0] CTRL_RST_VAL    = 32'h0000_0000;

  // Divider fields
  localparam int          DIV_N_LSB       = 0;
  localparam int          DIV_M_LSB       = 8;
  localparam int          DIV_O_LSB       = 16;
  localparam int          DIV_FBK_LSB     = 24;
  localparam logic [31:0] DIV_RST_VAL     = 32'h0101_0101;
  localparam logic [7:0]  OUTDIV_RST_VAL  = 8'h01;
  localparam logic [9:0]  MOC_LIMIT       = 10'h0FF;

  // Phase request fields
  localparam int          PH_STEP_LSB     = 0;
  localparam int          PH_MASK_LSB     = 8;

  // Interrupt bits
  localparam int          IRQ_LOCK_BIT    = 0;
  localparam int          IRQ_LOSS_BIT    = 1;
  localparam int          IRQ_PHASE_BIT   = 2;
  localparam int          IRQ_W           = 3;

  // Timing
  localparam int          CLK_PERIOD_PS   = 4000;
  localparam int          RST_MIN_PS      = 10000;
  localparam int          RST_MIN_CYC     = (RST_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          LOCK_CYC        = 64;
  localparam int          PH_SETUP_CYC    = 1;
  localparam int          PH_HOLD_CYC     = 4;
  localparam int          PH_GAP_CYC      = 4;

  typedef enum logic [2:0] {
    ST_RESET  = 3'b000,
    ST_HOLD   = 3'b001,
    ST_ACQ    = 3'b010,
    ST_LOCK_INDICATOR = 3'b011,
    ST_FAULT  = 3'b100
  } loop_state_t;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_SETUP = 2'b01,
    PH_APPLY = 2'b10,
    PH_GAP   = 2'b11
  } phase_state_t;

endpackage

// ### hdl/out_divider.sv
`timescale 1ns/1ps
module out_divider
  import pll_ctrl_pkg::*;
#(
  parameter int DW = 8
) (
  // Clock and control
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  input  wire logic          run,
  input  wire logic          pll_tick,
  // Settings
  input  wire logic [DW-1:0] divide,
  input  wire logic [2:0]    step_delay,
  // Output clock
  output logic               out_clk,
  output logic               out_edge
);

  logic [DW-1:0] cnt_ff;
  logic [DW-1:0] nxt_cnt;
  logic [3:0]    dly_ff;
  logic [3:0]    nxt_dly;
  logic          clk_ff;
  logic          nxt_clk;
  logic          edge_ff;
  logic          nxt_edge;

  // Each phase step, loaded while run is low, holds off the divider for one pll_tick
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_dly  = dly_ff;
    nxt_clk  = clk_ff;
    nxt_edge = 1'b0;
    if (!run) begin
      nxt_cnt = '0;
      nxt_clk = 1'b0;
      nxt_dly = {1'b0, step_delay};
    end else if (pll_tick) begin
      if (dly_ff != 4'h0) begin
        nxt_dly = dly_ff - 4'h1;
      end else if (cnt_ff + DW'(1) >= divide) begin
        nxt_cnt  = '0;
        nxt_clk  = ~clk_ff;
        nxt_edge = clk_ff;
      end else begin
        nxt_cnt = cnt_ff + DW'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff  <= '0;
      dly_ff  <= 4'h0;
      clk_ff  <= 1'b0;
      edge_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff  <= nxt_cnt;
      dly_ff  <= nxt_dly;
      clk_ff  <= nxt_clk;
      edge_ff <= nxt_edge;
    end
  end

  assign out_clk  = clk_ff;
  assign out_edge = edge_ff;

endmodule // out_divider

// ### hdl/pll_control_phase_shift.sv
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pll_control_phase_shift
  import pll_ctrl_pkg::*;
#(
  parameter int NOUT = 5,
  parameter int DW   = 8
) (
  // Clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // AXI4-Lite write
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Reference clocks and feedback (pins)
  input  wire logic [3:0]        ref_clk_in,
  input  wire logic              core_feedback_in,
  input  wire logic              io_feedback_in,
  // Loop outputs
  output logic [NOUT-1:0]        pll_out,
  output logic                   lock_indicator,
  output logic                   irq
);

  // Pin synchronisers
  logic [5:0] pin_s1_ff;
  logic [5:0] pin_s2_ff;
  logic [5:0] pin_prev_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_ff   <= 6'h00;
      pin_s2_ff   <= 6'h00;
      pin_prev_ff <= 6'h00;
    end else if (ce) begin
      pin_s1_ff   <= {io_feedback_in, core_feedback_in, ref_clk_in};
      pin_s2_ff   <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
    end
  end

  // Registers
  logic [31:0]     ctrl_ff, nxt_ctrl;
  logic [31:0]     div_ff, nxt_div;
  logic [DW*NOUT-1:0] outdiv_ff, nxt_outdiv;
  logic [15:0]     phreq_ff, nxt_phreq;
  logic [IRQ_W-1:0] ist_ff, nxt_ist, imask_ff, nxt_imask;
  logic            aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic            phgo_ff, nxt_phgo;
  logic [AXI_AW-1:0] awa_ff, nxt_awa;
  logic [31:0]     wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [1:0]      br_ff, nxt_br, rr_ff, nxt_rr;

  // Loop and phase state
  loop_state_t     lst_ff, nxt_lst;
  phase_state_t    pst_ff, nxt_pst;
  logic [7:0]      lcnt_ff, nxt_lcnt;
  logic [1:0]      sel_ff, nxt_sel;
  logic            lock_ff, nxt_lock;
  logic [2:0]      step_ff, nxt_step;
  logic [NOUT-1:0] tmask_ff, nxt_tmask;
  logic [2:0]      pcnt_ff, nxt_pcnt;
  logic            strobe_ff, nxt_strobe;
  logic [3*NOUT-1:0] cur_ff, nxt_cur;

  logic            loop_run, ref_edge, fb_edge, div_ok;
  logic [NOUT-1:0] out_clk_w, out_edge_w;
  logic            tgt_edge;
  logic [IRQ_W-1:0] ev;
  logic            wr_go, rd_go;

  assign loop_run = ctrl_ff[CTRL_RUN_BIT];
  assign ref_edge = pin_s2_ff[sel_ff] & ~pin_prev_ff[sel_ff];
  assign fb_edge  = (pin_s2_ff[4] & ~pin_prev_ff[4]) | (pin_s2_ff[5] & ~pin_prev_ff[5]);
  // Loop refuses to lock when the M*O*Cfbk product is out of range
  assign div_ok   = (32'(div_ff[DIV_M_LSB +: 8]) * 32'(div_ff[DIV_O_LSB +: 8])
                  * 32'(div_ff[DIV_FBK_LSB +: 8])) <= 32'(MOC_LIMIT)
                  && div_ff[DIV_N_LSB +: 8] != 8'h00 && div_ff[DIV_M_LSB +: 8] != 8'h00;

  // Loop state machine
  always_comb begin
    nxt_lst  = lst_ff;
    nxt_lcnt = lcnt_ff;
    nxt_sel  = sel_ff;
    nxt_lock = lock_ff;
    unique case (lst_ff)
      ST_RESET: begin
        nxt_lock = 1'b0;
        nxt_sel  = ctrl_ff[CTRL_SEL_LSB +: 2];
        nxt_lcnt = (lcnt_ff < 8'(RST_MIN_CYC)) ? lcnt_ff + 8'h01 : lcnt_ff;
        if (loop_run && lcnt_ff >= 8'(RST_MIN_CYC)) begin
          nxt_lst  = ST_ACQ;
          nxt_lcnt = 8'h00;
        end
      end
      ST_ACQ: begin
        if (ref_edge && div_ok) nxt_lcnt = lcnt_ff + 8'h01;
        if (lcnt_ff == 8'(LOCK_CYC)) begin
          nxt_lst  = ST_LOCK_INDICATOR;
          nxt_lock = 1'b1;
        end
      end
      ST_LOCK_INDICATOR: begin
        if (!div_ok) begin
          nxt_lst  = ST_FAULT;
          nxt_lock = 1'b0;
        end
      end
      ST_FAULT: begin
        nxt_lcnt = 8'h00;
        if (div_ok) nxt_lst = ST_ACQ;
      end
      default: nxt_lst = ST_RESET;
    endcase
    if (!loop_run) begin
      nxt_lst  = ST_RESET;
      nxt_lock = 1'b0;
      if (lst_ff != ST_RESET) nxt_lcnt = 8'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lst_ff  <= ST_RESET;
      lcnt_ff <= 8'h00;
      sel_ff  <= 2'h0;
      lock_ff <= 1'b0;
    end else if (ce) begin
      lst_ff  <= nxt_lst;
      lcnt_ff <= nxt_lcnt;
      sel_ff  <= nxt_sel;
      lock_ff <= nxt_lock;
    end
  end

  // Output dividers, one per output
  genvar gi;
  generate
    for (gi = 0; gi < NOUT; gi++) begin : g_out
      out_divider #(.DW(DW)) i_out_divider (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ce         (ce),
        .run        (lock_ff),
        .pll_tick   (ref_edge | fb_edge),
        .divide     (outdiv_ff[gi*DW +: DW]),
        .step_delay (cur_ff[gi*3 +: 3]),
        .out_clk    (out_clk_w[gi]),
        .out_edge   (out_edge_w[gi])
      );
    end
  endgenerate
  assign pll_out        = out_clk_w;
  assign lock_indicator = lock_ff;
  assign tgt_edge       = |(out_edge_w & phreq_ff[PH_MASK_LSB +: NOUT]);

  // Phase shift sequencer, timed in target output cycles
  always_comb begin
    nxt_pst    = pst_ff;
    nxt_pcnt   = pcnt_ff;
    nxt_step   = step_ff;
    nxt_tmask  = tmask_ff;
    nxt_strobe = strobe_ff;
    nxt_cur    = cur_ff;
    unique case (pst_ff)
      PH_IDLE: if (phgo_ff) begin
        nxt_step = phreq_ff[PH_STEP_LSB +: 3];
        nxt_pst  = PH_SETUP;
        nxt_pcnt = 3'h0;
      end
      PH_SETUP: if (tgt_edge) begin
        nxt_tmask  = phreq_ff[PH_MASK_LSB +: NOUT];
        nxt_strobe = 1'b1;
        nxt_pst    = PH_APPLY;
      end
      PH_APPLY: begin
        for (int i = 0; i < NOUT; i++) begin
          if (tmask_ff[i]) nxt_cur[i*3 +: 3] = step_ff;
        end
        if (tgt_edge) nxt_pcnt = pcnt_ff + 3'h1;
        if (pcnt_ff == 3'(PH_HOLD_CYC)) begin
          nxt_strobe = 1'b0;
          nxt_tmask  = '0;
          nxt_pcnt   = 3'h0;
          nxt_pst    = PH_GAP;
        end
      end
      PH_GAP: begin
        if (tgt_edge) nxt_pcnt = pcnt_ff + 3'h1;
        if (pcnt_ff == 3'(PH_GAP_CYC)) nxt_pst = PH_IDLE;
      end
    endcase
    if (!lock_ff) begin
      nxt_pst    = PH_IDLE;
      nxt_strobe = 1'b0;
      nxt_tmask  = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pst_ff    <= PH_IDLE;
      pcnt_ff   <= 3'h0;
      step_ff   <= 3'h0;
      tmask_ff  <= '0;
      strobe_ff <= 1'b0;
      cur_ff    <= '0;
    end else if (ce) begin
      pst_ff    <= nxt_pst;
      pcnt_ff   <= nxt_pcnt;
      step_ff   <= nxt_step;
      tmask_ff  <= nxt_tmask;
      strobe_ff <= nxt_strobe;
      cur_ff    <= nxt_cur;
    end
  end

  // Interrupt events
  assign ev[IRQ_LOCK_BIT]  = nxt_lock & ~lock_ff;
  assign ev[IRQ_LOSS_BIT]  = lock_ff & ~nxt_lock & loop_run;
  assign ev[IRQ_PHASE_BIT] = strobe_ff & ~nxt_strobe;
  assign irq = |(ist_ff & imask_ff);

  // AXI4-Lite slave
  assign s_axi_awready = ~aw_ff & ~bv_ff;
  assign s_axi_wready  = ~w_ff & ~bv_ff;
  assign s_axi_arready = ~rv_ff;
  assign s_axi_bvalid  = bv_ff;
  assign s_axi_bresp   = br_ff;
  assign s_axi_rvalid  = rv_ff;
  assign s_axi_rdata   = rd_ff;
  assign s_axi_rresp   = rr_ff;
  assign wr_go = (aw_ff | s_axi_awvalid) & (w_ff | s_axi_wvalid) & ~bv_ff;
  assign rd_go = s_axi_arvalid & ~rv_ff;

  always_comb begin
    logic [AXI_AW-1:0] wa;
    logic [31:0]       wd;
    logic [31:0]       ov;
    wa = aw_ff ? awa_ff : s_axi_awaddr;
    wd = w_ff ? wd_ff : s_axi_wdata;
    ov = 32'h0;
    nxt_aw = aw_ff; nxt_w = w_ff; nxt_awa = awa_ff; nxt_wd = wd_ff;
    nxt_bv = bv_ff; nxt_br = br_ff; nxt_rv = rv_ff; nxt_rd = rd_ff; nxt_rr = rr_ff;
    nxt_ctrl = ctrl_ff; nxt_div = div_ff; nxt_outdiv = outdiv_ff; nxt_phreq = phreq_ff;
    nxt_imask = imask_ff; nxt_phgo = 1'b0;
    nxt_ist = ist_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw = 1'b1; nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w = 1'b1; nxt_wd = s_axi_wdata;
    end
    if (bv_ff && s_axi_bready) nxt_bv = 1'b0;
    if (wr_go) begin
      nxt_aw = 1'b0; nxt_w = 1'b0; nxt_bv = 1'b1; nxt_br = RESP_OKAY;
      unique case (wa)
        OFS_CTRL:     nxt_ctrl = wd & 32'h0000_0031;
        OFS_DIV:      nxt_div = wd;
        OFS_OUTDIV:   for (int i = 0; i < NOUT; i++) nxt_outdiv[i*DW +: DW] = wd[i*DW/NOUT*0 +: DW];
        OFS_PHASE:    begin
          nxt_phreq = wd[15:0] & 16'h1F07;
          nxt_phgo  = 1'b1;
        end
        OFS_IRQ_STAT: nxt_ist = ist_ff & ~wd[IRQ_W-1:0];
        OFS_IRQ_MASK: nxt_imask = wd[IRQ_W-1:0];
        default:      nxt_br = RESP_SLVERR;
      endcase
    end
    nxt_ist = nxt_ist | ev; // Set wins over clear
    if (rv_ff && s_axi_rready) nxt_rv = 1'b0;
    if (rd_go) begin
      nxt_rv = 1'b1; nxt_rr = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL:      ov = ctrl_ff;
        OFS_DIV:       ov = div_ff;
        OFS_OUTDIV:    ov = 32'(outdiv_ff[DW-1:0]);
        OFS_PHASE:     ov = {16'h0, phreq_ff};
        OFS_STATUS:    ov = {24'h0, 1'b0, pst_ff, div_ok, lst_ff, lock_ff} & 32'h0000_00FF;
        OFS_IRQ_STAT:  ov = 32'(ist_ff);
        OFS_IRQ_MASK:  ov = 32'(imask_ff);
        OFS_PHASE_CUR: ov = 32'(cur_ff);
        default:       nxt_rr = RESP_SLVERR;
      endcase
      nxt_rd = ov;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0; w_ff <= 1'b0; bv_ff <= 1'b0; rv_ff <= 1'b0;
      awa_ff <= '0; wd_ff <= 32'h0; rd_ff <= 32'h0; br_ff <= 2'h0; rr_ff <= 2'h0;
      ctrl_ff <= CTRL_RST_VAL; div_ff <= DIV_RST_VAL;
      outdiv_ff <= {NOUT{OUTDIV_RST_VAL}};
      phreq_ff <= 16'h0; phgo_ff <= 1'b0; ist_ff <= '0; imask_ff <= '0;
    end else if (ce) begin
      aw_ff <= nxt_aw; w_ff <= nxt_w; bv_ff <= nxt_bv; rv_ff <= nxt_rv;
      awa_ff <= nxt_awa; wd_ff <= nxt_wd; rd_ff <= nxt_rd; br_ff <= nxt_br; rr_ff <= nxt_rr;
      ctrl_ff <= nxt_ctrl; div_ff <= nxt_div; outdiv_ff <= nxt_outdiv;
      phreq_ff <= nxt_phreq; phgo_ff <= nxt_phgo; ist_ff <= nxt_ist; imask_ff <= nxt_imask;
    end
  end

endmodule // pll_control_phase_shift

// ### sim/pll_control_phase_shift_chk.sv
`timescale 1ns/1ps
module pll_control_phase_shift_chk #(
  parameter int NOUT = 5
) (
  // Clock and reset
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            ce,
  // Register bus
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  // Loop outputs
  input wire logic [NOUT-1:0] pll_out,
  input wire logic            lock_indicator,
  input wire logic            irq
);
  default clocking cb @(posedge aclk); endclocking

  logic [7:0] low_cnt_ff;
  logic [7:0] nxt_low_cnt;

  // Consecutive cycles with lock low, saturating
  always_comb begin
    nxt_low_cnt = low_cnt_ff;
    if (lock_indicator) begin
      nxt_low_cnt = 8'h00;
    end else if (low_cnt_ff != 8'hFF) begin
      nxt_low_cnt = low_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_ff <= 8'h00;
    end else if (ce) begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end

  sequence wr_both_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence

  reset_quiet_a: assert property ((!aresetn && ce) |=> !lock_indicator && !irq && pll_out == '0)
    else $error("outputs not quiet after reset");
  reset_ready_a: assert property ((!aresetn && ce) |=> s_axi_awready && s_axi_arready && !s_axi_bvalid)
    else $error("bus not idle after reset");
  lock_count_a: assert property (disable iff (!aresetn) $rose(lock_indicator) |-> low_cnt_ff >= 8'h40)
    else $error("lock rose too early");
  wr_resp_a: assert property (disable iff (!aresetn) wr_both_s |=> s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (disable iff (!aresetn) rd_take_s |=> s_axi_rvalid)
    else $error("read response late");
  aw_block_a: assert property (disable iff (!aresetn) s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken during response");
  ar_block_a: assert property (disable iff (!aresetn) s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  b_single_a: assert property (disable iff (!aresetn) s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  r_single_a: assert property (disable iff (!aresetn) s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
endmodule // pll_control_phase_shift_chk

bind pll_control_phase_shift pll_control_phase_shift_chk #(.NOUT(NOUT)) i_pll_control_phase_shift_chk (
  .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .pll_out, .lock_indicator, .irq
);

// ### sim/pll_fabric_model.sv
`timescale 1ns/1ps
module pll_fabric_model (
  // Bench control
  input  wire logic [1:0] ref_pick,
  input  wire logic       ref_en,
  // Loop outputs
  input  wire logic [4:0] pll_out, // outputs 2 to 4 never fed back
  // Pins into the block
  output logic      [3:0] ref_clk_in,
  output logic            core_feedback_in,
  output logic            io_feedback_in
);
  logic ref_osc;

  initial begin
    ref_osc = 1'b0;
    forever #10 ref_osc = ~ref_osc;
  end

  // Only the picked input toggles; the rest sit low
  always_comb begin
    ref_clk_in = 4'h0;
    if (ref_en) begin
      ref_clk_in[ref_pick] = ref_osc;
    end
  end

  assign core_feedback_in = pll_out[0];
  assign io_feedback_in   = pll_out[1];
endmodule // pll_fabric_model

// ### sim/test_pll_control_phase_shift.sv
`timescale 1ns/1ps
module test_pll_control_phase_shift;
  import pll_ctrl_pkg::*;
  logic              aclk, aresetn, ce, ref_en, irq, lock_indicator;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]        s_axi_wstrb, ref_clk_in;
  logic [1:0]        s_axi_bresp, s_axi_rresp, ref_pick, rsp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, core_feedback_in, io_feedback_in;
  logic [4:0]        pll_out;
  int                n_fail, checks_done;

  pll_control_phase_shift i_pll_control_phase_shift (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ref_clk_in, .core_feedback_in, .io_feedback_in, .pll_out,
    .lock_indicator, .irq);
  pll_fabric_model i_pll_fabric_model (
    .ref_pick, .ref_en, .pll_out, .ref_clk_in, .core_feedback_in, .io_feedback_in);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic stuck();
    n_fail++;
    $display("FAIL %0t wait ran out", $time);
    conclude();
  endtask

  // Look at outputs mid-cycle, once they have settled
  task automatic settle();
    @(negedge aclk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic ad, dd;
    int   n;
    if (!aclk) @(posedge aclk);
    ad = 1'b1;
    dd = 1'b1;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (ad && s_axi_awready) begin
        ad = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (dd && s_axi_wready) begin
        dd = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      n++;
      if (n > 100) stuck();
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask

  task automatic rd(input logic [5:0] a);
    int n;
    if (!aclk) @(posedge aclk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 100) stuck();
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  task automatic wait_lock(input logic v, input int lim);
    int n;
    n = 0;
    while (lock_indicator !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask

  // Bounded wait for one output clock to toggle
  task automatic out_moves(input int k);
    logic v;
    int   n;
    v = pll_out[k];
    n = 0;
    while (pll_out[k] === v && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(pll_out[k] !== v), 32'h1, "output clock stuck");
  endtask

  // Loop held in reset while the select moves
  task automatic sel_run(input logic [1:0] s);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, {26'h0, s, 4'h0});
    repeat (4) @(posedge aclk);
    wr(OFS_CTRL, {26'h0, s, 4'h1});
  endtask

  task automatic shift_done();
    int n;
    n = 0;
    do begin
      rd(OFS_IRQ_STAT);
      n++;
      if (n > 300) stuck();
    end while (rv[IRQ_PHASE_BIT] !== 1'b1);
  endtask

  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1; // Responses always accepted
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    ref_pick = 2'h2;
    ref_en = 1'b1;
    n_fail = 0;
    checks_done = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_CTRL);
    chk(rv, CTRL_RST_VAL, "ctrl reset");
    rd(OFS_DIV);
    chk(rv, DIV_RST_VAL, "div reset");
    rd(OFS_OUTDIV);
    chk(rv, {24'h0, OUTDIV_RST_VAL}, "outdiv reset");
    rd(6'h20);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(6'h24, 32'hFFFF_FFFF);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
    chk(32'(lock_indicator), 32'h0, "lock after reset");
    $display("test reset_values done");
    sel_run(2'h1);
    wait_lock(1'b1, 600);
    chk(32'(lock_indicator), 32'h0, "lock_indicator on idle input");
    sel_run(2'h2);
    wait_lock(1'b1, 2000);
    chk(32'(lock_indicator), 32'h1, "no lock");
    out_moves(1);
    out_moves(4);
    rd(OFS_STATUS);
    chk({31'h0, rv[0]}, 32'h1, "status lock");
    $display("test ref_select done");
    rd(OFS_IRQ_STAT);
    chk({31'h0, rv[IRQ_LOCK_BIT]}, 32'h1, "lock event");
    chk(32'(irq), 32'h0, "irq while masked");
    wr(OFS_IRQ_MASK, 32'h0000_0003);
    settle();
    chk(32'(irq), 32'h1, "irq unmasked");
    wr(OFS_IRQ_STAT, 32'h0000_0001);
    settle();
    chk(32'(irq), 32'h0, "irq after clear");
    $display("test irq done");
    wr(OFS_DIV, 32'h0102_8001);
    wait_lock(1'b0, 200);
    chk(32'(lock_indicator), 32'h0, "lock kept past 255");
    settle();
    chk(32'(irq), 32'h1, "loss irq");
    rd(OFS_STATUS);
    chk({31'h0, rv[4]}, 32'h0, "range flag");
    wr(OFS_DIV, 32'h0101_FF01);
    rd(OFS_STATUS);
    chk({31'h0, rv[4]}, 32'h1, "range flag at 255");
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    sel_run(2'h2);
    wait_lock(1'b1, 2000);
    chk(32'(lock_indicator), 32'h1, "no lock at 255");
    $display("test div_range done");
    wr(OFS_IRQ_MASK, 32'h0000_0004);
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    wr(OFS_PHASE, 32'h0000_0203);
    shift_done();
    settle();
    chk(32'(irq), 32'h1, "shift irq");
    rd(OFS_PHASE_CUR);
    chk(rv, 32'h0000_0018, "one output shifted");
    wr(OFS_IRQ_STAT, 32'h0000_0004);
    repeat (200) @(posedge aclk);
    wr(OFS_PHASE, 32'h0000_1107);
    shift_done();
    rd(OFS_PHASE_CUR);
    chk(rv, 32'h0000_701F, "two outputs shifted");
    $display("test phase_shift done");
    wr(OFS_CTRL, 32'h0000_0000);
    wait_lock(1'b0, 50);
    chk(32'(lock_indicator), 32'h0, "lock with run clear");
    settle();
    chk(32'(pll_out), 32'h0, "outputs run while unlocked");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_DIV);
    chk(rv, DIV_RST_VAL, "div after reset");
    rd(OFS_PHASE_CUR);
    chk(rv, 32'h0, "phase after reset");
    $display("test run_reset done");
    conclude();
  end
endmodule // test_pll_control_phase_shift
